// >>> pkg/pfi_pkg.sv
// Shared constants, types and pattern table of the printer fault indicator
package pfi_pkg;

	// Clock and prescaler
	localparam int CLK_HZ = 25_000_000;
	localparam int TICK_MS = 1;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

	// Flash intervals in milliseconds
	localparam int FL_HEAD_MS = 500;
	localparam int FL_CUTTER_MS = 125;
	localparam int FL_RAM_MS = 1000;
	localparam int FL_EEPROM_MS = 750;
	localparam int FL_FLASH_MS = 500;
	localparam int FL_THERM_MS = 1500;
	localparam int FL_SUPPLY_MS = 2000;
	localparam int FL_PAPER_OUT_MS = 500;
	localparam int FL_NEAR_END_MS = 2000;
	localparam int HOME_TIMEOUT_MS = 1000;

	// Interval counts in prescaler ticks
	localparam int INT_W = 11;
	localparam logic [INT_W-1:0] T_HEAD = INT_W'(FL_HEAD_MS / TICK_MS);
	localparam logic [INT_W-1:0] T_CUTTER = INT_W'(FL_CUTTER_MS / TICK_MS);
	localparam logic [INT_W-1:0] T_RAM = INT_W'(FL_RAM_MS / TICK_MS);
	localparam logic [INT_W-1:0] T_EEPROM = INT_W'(FL_EEPROM_MS / TICK_MS);
	localparam logic [INT_W-1:0] T_FLASH = INT_W'(FL_FLASH_MS / TICK_MS);
	localparam logic [INT_W-1:0] T_THERM = INT_W'(FL_THERM_MS / TICK_MS);
	localparam logic [INT_W-1:0] T_SUPPLY = INT_W'(FL_SUPPLY_MS / TICK_MS);
	localparam logic [INT_W-1:0] T_PAPER_OUT = INT_W'(FL_PAPER_OUT_MS / TICK_MS);
	localparam logic [INT_W-1:0] T_NEAR_END = INT_W'(FL_NEAR_END_MS / TICK_MS);
	localparam int HOME_W = 10;
	localparam logic [HOME_W-1:0] T_HOME = HOME_W'(HOME_TIMEOUT_MS / TICK_MS);

	// Condition indices, lowest index is most severe
	localparam int NCOND = 10;
	localparam int CIDX_W = 4;
	localparam logic [CIDX_W-1:0] C_SUPPLY = 4'h0;
	localparam logic [CIDX_W-1:0] C_THERM = 4'h1;
	localparam logic [CIDX_W-1:0] C_RAM = 4'h2;
	localparam logic [CIDX_W-1:0] C_EEPROM = 4'h3;
	localparam logic [CIDX_W-1:0] C_FLASH = 4'h4;
	localparam logic [CIDX_W-1:0] C_CUTTER = 4'h5;
	localparam logic [CIDX_W-1:0] C_HEAD = 4'h6;
	localparam logic [CIDX_W-1:0] C_COVER = 4'h7;
	localparam logic [CIDX_W-1:0] C_PAPER_OUT = 4'h8;
	localparam logic [CIDX_W-1:0] C_NEAR_END = 4'h9;
	localparam logic [CIDX_W-1:0] C_NONE = 4'hA;

	// Register byte offsets and fields
	localparam int ADR_W = 4;
	localparam logic [ADR_W-1:0] REG_STATUS = 4'h0;
	localparam logic [ADR_W-1:0] REG_MASK = 4'h4;
	localparam logic [ADR_W-1:0] REG_CTRL = 4'h8;
	localparam logic [ADR_W-1:0] REG_COND = 4'hC;
	localparam int CTRL_FEED_BIT = 0;
	localparam int COND_HOME_OK_BIT = 16;
	localparam int COND_ROLL_SEEN_BIT = 17;
	localparam logic [NCOND-1:0] MASK_RST = 10'h000;

	typedef enum logic [1:0] {
		LM_OFF = 2'h0,
		LM_ON = 2'h1,
		LM_FLASH = 2'h2
	} pfi_lamp_mode_t;

	typedef enum logic [2:0] {
		HS_WAIT = 3'h1,
		HS_OK = 3'h2,
		HS_FAIL = 3'h4
	} pfi_home_t;

	typedef struct packed {
		pfi_lamp_mode_t pwr;
		pfi_lamp_mode_t err;
		logic [INT_W-1:0] ticks;
	} pfi_pattern_t;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] sel;
		logic [ADR_W-1:0] adr;
		logic [31:0] dat;
	} pfi_wb_req_t;

	typedef struct packed {
		logic head_hot;
		logic cover_open;
		logic cutter_fail;
		logic cutter_home;
		logic ram_fault;
		logic eeprom_fault;
		logic flash_fault;
		logic therm_fault;
		logic supply_fault;
		logic paper_out;
		logic roll_present;
		logic paper_near_end;
		logic feed_button;
	} pfi_pins_t;

	// Lamp pattern of a condition
	function automatic pfi_pattern_t pfi_pattern(input logic [CIDX_W-1:0] idx);
		pfi_pattern_t p;
		p = '{pwr: LM_OFF, err: LM_FLASH, ticks: T_SUPPLY};
		case (idx)
			C_SUPPLY: p.ticks = T_SUPPLY;
			C_THERM: p.ticks = T_THERM;
			C_RAM: p.ticks = T_RAM;
			C_EEPROM: p.ticks = T_EEPROM;
			C_FLASH: p.ticks = T_FLASH;
			C_CUTTER: p.ticks = T_CUTTER;
			C_HEAD: p = '{pwr: LM_FLASH, err: LM_OFF, ticks: T_HEAD};
			C_COVER: p = '{pwr: LM_ON, err: LM_ON, ticks: T_HEAD};
			C_PAPER_OUT: p = '{pwr: LM_ON, err: LM_FLASH, ticks: T_PAPER_OUT};
			C_NEAR_END: p = '{pwr: LM_ON, err: LM_FLASH, ticks: T_NEAR_END};
			default: p = '{pwr: LM_ON, err: LM_OFF, ticks: T_SUPPLY};
		endcase
		return p;
	endfunction

endpackage

// >>> verilog/pfi_sync.sv
// Two-flop synchroniser for the mechanism and panel inputs
module pfi_sync #(
	parameter int W = 1
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} pfi_sync_st_t;

	pfi_sync_st_t st_q;
	pfi_sync_st_t st_d;

	if (W < 1) begin : g_chk
		$error("pfi_sync width must be at least one");
	end

	always_comb begin
		st_d.s1 = async_i;
		st_d.s2 = st_q.s1;
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign sync_o = st_q.s2;

endmodule

// >>> verilog/pfi_flasher.sv
// Millisecond prescaler and flash phase generator
module pfi_flasher #(
	parameter int TICK_CYCLES = pfi_pkg::TICK_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic restart,
	input wire logic [pfi_pkg::INT_W-1:0] interval,
	output logic ms_tick,
	output logic phase
);

	localparam int PRE_W = $clog2(TICK_CYCLES);
	localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);
	localparam logic [pfi_pkg::INT_W-1:0] ONE = 11'h001;

	typedef struct packed {
		logic [PRE_W-1:0] pre;
		logic [pfi_pkg::INT_W-1:0] cnt;
		logic phase;
	} pfi_flash_st_t;

	pfi_flash_st_t st_q;
	pfi_flash_st_t st_d;

	if (TICK_CYCLES < 2) begin : g_chk
		$error("pfi_flasher needs at least two cycles per tick");
	end

	assign ms_tick = (st_q.pre == PRE_LAST);

	always_comb begin
		st_d = st_q;
		if (restart) begin
			st_d.pre = '0;
			st_d.cnt = '0;
			st_d.phase = 1'b1;
		end else begin
			st_d.pre = ms_tick ? '0 : st_q.pre + PRE_W'(1);
			if (ms_tick) begin
				if (st_q.cnt >= interval - ONE) begin
					st_d.cnt = '0;
					st_d.phase = ~st_q.phase;
				end else begin
					st_d.cnt = st_q.cnt + ONE;
				end
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			st_q <= '{pre: '0, cnt: '0, phase: 1'b1};
		end else begin
			st_q <= st_d;
		end
	end

	assign phase = st_q.phase;

endmodule

// >>> verilog/pfi_top.sv
// Fault indicator top: lamp patterns, fault latches and Wishbone registers
//
// Register access over Wishbone and the placing of the registers were left to the implementer.

// Summary of operation
// - Green lamp steady when nothing overrides it
// - Feed button drives paper feed while held
// - Head hot flashes green 0.5 s, self-clears
// - Cover open lights both lamps, self-clears
// - Cutter fault flashes red 0.125 s until reset
// - Cutter not homed after reset stays latched
// - Working memory fault flashes red 1.0 s, permanent
// - Parameter store fault flashes red 0.75 s, permanent
// - Program flash fault flashes red 0.5 s, permanent
// - Sensor 1.5 s, supply 2 s, both permanent
// - Paper out flashes red 0.5 s until reload
// - Near end flashes red 2 s, printing continues
module pfi_top #(
	parameter int TICK_CYCLES = pfi_pkg::TICK_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire pfi_pkg::pfi_wb_req_t wb_req,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire pfi_pkg::pfi_pins_t pins,
	output logic power_lamp,
	output logic error_lamp,
	output logic feed_motor,
	output logic print_enable,
	output logic irq
);

	localparam int N = pfi_pkg::NCOND;
	localparam logic [pfi_pkg::HOME_W-1:0] HOME_ONE = 10'h001;

	typedef struct packed {
		pfi_pkg::pfi_home_t home;
		logic [pfi_pkg::HOME_W-1:0] home_cnt;
		logic cutter_lat;
		logic supply_lat;
		logic therm_lat;
		logic ram_lat;
		logic eeprom_lat;
		logic flash_lat;
		logic paper_lat;
		logic roll_seen;
		logic [N-1:0] cond_prev;
		logic [N-1:0] status;
		logic [N-1:0] mask;
		logic ctrl_feed;
		logic [pfi_pkg::CIDX_W-1:0] pat_idx;
		logic ack;
		logic [31:0] dat;
		logic power_lamp;
		logic error_lamp;
		logic feed;
		logic print_en;
		logic irq;
	} pfi_top_st_t;

	pfi_top_st_t st_q;
	pfi_top_st_t st_d;

	logic [$bits(pfi_pkg::pfi_pins_t)-1:0] pins_s_vec;
	pfi_pkg::pfi_pins_t pin_s;
	logic [N-1:0] cond;
	logic [pfi_pkg::CIDX_W-1:0] idx_c;
	pfi_pkg::pfi_pattern_t pat_c;
	logic restart;
	logic ms_tick;
	logic phase;
	logic flash_on;
	logic bus_hit;
	logic [31:0] rd_mux;

	if (TICK_CYCLES < 2) begin : g_chk
		$error("pfi_top needs at least two cycles per tick");
	end

	if (N <= 8 || N > pfi_pkg::COND_HOME_OK_BIT) begin : g_chk_ncond
		$error("pfi_top condition count does not fit the register layout");
	end

	if (pfi_pkg::CTRL_FEED_BIT > 7) begin : g_chk_feed
		$error("pfi_top feed bit must sit in the low byte");
	end

	if (pfi_pkg::T_HOME == '0) begin : g_chk_home
		$error("pfi_top home timeout must not be zero");
	end

	if (pfi_pkg::FL_SUPPLY_MS / pfi_pkg::TICK_MS >= 2 ** pfi_pkg::INT_W) begin : g_chk_int
		$error("pfi_top flash interval does not fit its counter");
	end

	if (pfi_pkg::COND_ROLL_SEEN_BIT > 31) begin : g_chk_roll
		$error("pfi_top roll bit lies outside the data word");
	end

	pfi_sync #(
		.W($bits(pfi_pkg::pfi_pins_t))
	) u_sync (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.async_i(pins),
		.sync_o(pins_s_vec)
	);

	assign pin_s = pfi_pkg::pfi_pins_t'(pins_s_vec);

	// Live condition vector, severity order by index
	always_comb begin
		cond = '0;
		cond[pfi_pkg::C_SUPPLY] = st_q.supply_lat;
		cond[pfi_pkg::C_THERM] = st_q.therm_lat;
		cond[pfi_pkg::C_RAM] = st_q.ram_lat;
		cond[pfi_pkg::C_EEPROM] = st_q.eeprom_lat;
		cond[pfi_pkg::C_FLASH] = st_q.flash_lat;
		cond[pfi_pkg::C_CUTTER] = st_q.cutter_lat;
		cond[pfi_pkg::C_HEAD] = pin_s.head_hot;
		cond[pfi_pkg::C_COVER] = pin_s.cover_open;
		cond[pfi_pkg::C_PAPER_OUT] = st_q.paper_lat;
		cond[pfi_pkg::C_NEAR_END] = pin_s.paper_near_end;
	end

	// Pick the most severe active condition
	always_comb begin
		idx_c = pfi_pkg::C_NONE;
		for (int i = N - 1; i >= 0; i--) begin
			if (cond[i]) begin
				idx_c = pfi_pkg::CIDX_W'(i);
			end
		end
	end

	assign pat_c = pfi_pkg::pfi_pattern(idx_c);
	assign restart = (idx_c != st_q.pat_idx);

	pfi_flasher #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_flash (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.restart(restart),
		.interval(pat_c.ticks),
		.ms_tick(ms_tick),
		.phase(phase)
	);

	// A new pattern starts lit
	assign flash_on = restart | phase;

	assign bus_hit = wb_req.cyc & wb_req.stb & ~st_q.ack;

	// Register read mux
	always_comb begin
		rd_mux = '0;
		unique case (wb_req.adr)
			pfi_pkg::REG_STATUS: rd_mux[N-1:0] = st_q.status;
			pfi_pkg::REG_MASK: rd_mux[N-1:0] = st_q.mask;
			pfi_pkg::REG_CTRL: rd_mux[pfi_pkg::CTRL_FEED_BIT] = st_q.ctrl_feed;
			pfi_pkg::REG_COND: begin
				rd_mux[N-1:0] = cond;
				rd_mux[pfi_pkg::COND_HOME_OK_BIT] = (st_q.home == pfi_pkg::HS_OK);
				rd_mux[pfi_pkg::COND_ROLL_SEEN_BIT] = st_q.roll_seen;
			end
			default: rd_mux = '0;
		endcase
	end

	always_comb begin
		st_d = st_q;

		// Permanent faults latch until reset
		st_d.supply_lat = st_q.supply_lat | pin_s.supply_fault;
		st_d.therm_lat = st_q.therm_lat | pin_s.therm_fault;
		st_d.ram_lat = st_q.ram_lat | pin_s.ram_fault;
		st_d.eeprom_lat = st_q.eeprom_lat | pin_s.eeprom_fault;
		st_d.flash_lat = st_q.flash_lat | pin_s.flash_fault;

		// Cutter failure latches until reset; a homing timeout after reset latches it too
		st_d.cutter_lat = st_q.cutter_lat | pin_s.cutter_fail;
		unique case (st_q.home)
			pfi_pkg::HS_WAIT: begin
				if (pin_s.cutter_home) begin
					st_d.home = pfi_pkg::HS_OK;
				end else if (ms_tick) begin
					st_d.home_cnt = st_q.home_cnt + HOME_ONE;
					if (st_q.home_cnt >= pfi_pkg::T_HOME - HOME_ONE) begin
						st_d.home = pfi_pkg::HS_FAIL;
					end
				end
			end
			pfi_pkg::HS_OK: st_d.home = pfi_pkg::HS_OK;
			pfi_pkg::HS_FAIL: begin
				st_d.home = pfi_pkg::HS_FAIL;
				st_d.cutter_lat = 1'b1;
			end
			default: st_d.home = pfi_pkg::HS_FAIL;
		endcase

		// Paper out clears after a new roll and a closed cover
		if (st_q.paper_lat && pin_s.roll_present && !pin_s.paper_out) begin
			st_d.roll_seen = 1'b1;
		end
		if (st_q.roll_seen && pin_s.roll_present && !pin_s.cover_open) begin
			st_d.paper_lat = 1'b0;
			st_d.roll_seen = 1'b0;
		end
		if (pin_s.paper_out) begin
			st_d.paper_lat = 1'b1;
			st_d.roll_seen = 1'b0;
		end

		// Lamp pattern
		st_d.pat_idx = idx_c;
		unique case (pat_c.pwr)
			pfi_pkg::LM_ON: st_d.power_lamp = 1'b1;
			pfi_pkg::LM_FLASH: st_d.power_lamp = flash_on;
			default: st_d.power_lamp = 1'b0;
		endcase
		unique case (pat_c.err)
			pfi_pkg::LM_ON: st_d.error_lamp = 1'b1;
			pfi_pkg::LM_FLASH: st_d.error_lamp = flash_on;
			default: st_d.error_lamp = 1'b0;
		endcase

		// Feed follows the button or the software request
		st_d.feed = pin_s.feed_button | st_q.ctrl_feed;

		// Printing halts on any condition except near end
		st_d.print_en = (cond & ~(N'(1) << pfi_pkg::C_NEAR_END)) == '0;

		// Bus access, one wait state
		st_d.ack = bus_hit;
		st_d.dat = '0;
		if (bus_hit && wb_req.we) begin
			if (wb_req.adr == pfi_pkg::REG_MASK) begin
				if (wb_req.sel[0]) begin
					st_d.mask[7:0] = wb_req.dat[7:0];
				end
				if (wb_req.sel[1]) begin
					st_d.mask[N-1:8] = wb_req.dat[N-1:8];
				end
			end
			if (wb_req.adr == pfi_pkg::REG_CTRL && wb_req.sel[0]) begin
				st_d.ctrl_feed = wb_req.dat[pfi_pkg::CTRL_FEED_BIT];
			end
		end
		if (bus_hit && !wb_req.we) begin
			st_d.dat = rd_mux;
		end

		// Sticky events: read clears, a new event wins
		st_d.cond_prev = cond;
		if (bus_hit && !wb_req.we && wb_req.adr == pfi_pkg::REG_STATUS) begin
			st_d.status = '0;
		end
		st_d.status = st_d.status | (cond & ~st_q.cond_prev);
		st_d.irq = |(st_d.status & st_d.mask);
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			st_q <= '{
				home: pfi_pkg::HS_WAIT,
				home_cnt: '0,
				cutter_lat: 1'b0,
				supply_lat: 1'b0,
				therm_lat: 1'b0,
				ram_lat: 1'b0,
				eeprom_lat: 1'b0,
				flash_lat: 1'b0,
				paper_lat: 1'b0,
				roll_seen: 1'b0,
				cond_prev: '0,
				status: '0,
				mask: pfi_pkg::MASK_RST,
				ctrl_feed: 1'b0,
				pat_idx: pfi_pkg::C_NONE,
				ack: 1'b0,
				dat: '0,
				power_lamp: 1'b0,
				error_lamp: 1'b0,
				feed: 1'b0,
				print_en: 1'b0,
				irq: 1'b0
			};
		end else begin
			st_q <= st_d;
		end
	end

	assign wb_dat_o = st_q.dat;
	assign wb_ack_o = st_q.ack;
	assign power_lamp = st_q.power_lamp;
	assign error_lamp = st_q.error_lamp;
	assign feed_motor = st_q.feed;
	assign print_enable = st_q.print_en;
	assign irq = st_q.irq;

endmodule

// >>> tb/pfi_properties.sv
// Port-level checks of the fault indicator
module pfi_properties (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire pfi_pkg::pfi_wb_req_t wb_req,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire pfi_pkg::pfi_pins_t pins,
	input wire logic power_lamp,
	input wire logic error_lamp,
	input wire logic feed_motor,
	input wire logic print_enable,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	logic flt_q;
	logic home_q;
	logic [9:0] age_q;
	logic calm;
	assign calm = !pins.head_hot && !pins.cover_open && !pins.paper_out && pins.roll_present
		&& home_q && !flt_q;
	// Latched faults, and cutter homing seen well before the home timeout
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			flt_q <= 1'b0;
			home_q <= 1'b0;
			age_q <= 10'h000;
		end else begin
			flt_q <= flt_q | pins.cutter_fail | pins.ram_fault | pins.eeprom_fault
				| pins.flash_fault | pins.therm_fault | pins.supply_fault;
			home_q <= home_q | (pins.cutter_home && age_q != 10'h3E8);
			age_q <= (age_q == 10'h3E8) ? age_q : age_q + 10'h001;
		end
	end
	property p_ack;
		wb_req.cyc && wb_req.stb && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack: assert property (p_ack) else $error("ack missing");
	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
	property p_idle;
		(calm && !pins.paper_near_end)[*8] |-> power_lamp && !error_lamp;
	endproperty
	a_idle: assert property (p_idle) else $error("idle lamps wrong");
	property p_feed;
		pins.feed_button[*4] |-> feed_motor;
	endproperty
	a_feed: assert property (p_feed) else $error("feed not driven");
	property p_head;
		(pins.head_hot && home_q && !flt_q)[*5] |-> !error_lamp;
	endproperty
	a_head: assert property (p_head) else $error("red lit on hot head");
	property p_cover;
		(pins.cover_open && !pins.head_hot && home_q && !flt_q)[*5] |-> power_lamp && error_lamp;
	endproperty
	a_cover: assert property (p_cover) else $error("cover lamps wrong");
	property p_dark;
		flt_q[*5] |-> !power_lamp;
	endproperty
	a_dark: assert property (p_dark) else $error("green lit on fault");
	property p_print;
		calm[*8] |-> print_enable;
	endproperty
	a_print: assert property (p_print) else $error("printing stopped");
endmodule
bind pfi_top pfi_properties u_props (.sys_clk(sys_clk), .rstn(rstn), .wb_req(wb_req),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pins(pins), .power_lamp(power_lamp),
	.error_lamp(error_lamp), .feed_motor(feed_motor), .print_enable(print_enable), .irq(irq));

// >>> tb/pfi_mech_model.sv
// Mechanism, sensor and panel button model
module pfi_mech_model (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [9:0] cond,
	input wire logic stuck,
	input wire logic feed,
	output pfi_pkg::pfi_pins_t pins
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] home_q;
	// Cutter reaches home some cycles after power-up unless jammed
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			home_q <= 4'h0;
		end else if (home_q != 4'hF) begin
			home_q <= home_q + 4'h1;
		end
	end
	assign pins = '{head_hot: cond[6], cover_open: cond[7], cutter_fail: cond[5],
		cutter_home: !stuck && home_q == 4'hF, ram_fault: cond[2], eeprom_fault: cond[3],
		flash_fault: cond[4], therm_fault: cond[1], supply_fault: cond[0],
		paper_out: cond[8], roll_present: !cond[8], paper_near_end: cond[9], feed_button: feed};
endmodule

// >>> tb/testbench.sv
// Self-checking bench of the fault indicator
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int TC = 2;
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	pfi_pkg::pfi_wb_req_t wb_req = '0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o, power_lamp, error_lamp, feed_motor, print_enable, irq;
	logic [9:0] cond = 10'h000;
	logic stuck = 1'b0;
	logic feed = 1'b0;
	pfi_pkg::pfi_pins_t pins;
	logic [31:0] rd;
	int n_mismatch = 0;
	int checks = 0;
	int ms[10] = '{pfi_pkg::FL_SUPPLY_MS, pfi_pkg::FL_THERM_MS, pfi_pkg::FL_RAM_MS,
		pfi_pkg::FL_EEPROM_MS, pfi_pkg::FL_FLASH_MS, pfi_pkg::FL_CUTTER_MS, pfi_pkg::FL_HEAD_MS,
		0, pfi_pkg::FL_PAPER_OUT_MS, pfi_pkg::FL_NEAR_END_MS};
	always #20 sys_clk = ~sys_clk;
	pfi_mech_model u_model (.sys_clk(sys_clk), .rstn(rstn), .cond(cond), .stuck(stuck),
		.feed(feed), .pins(pins));
	pfi_top #(.TICK_CYCLES(TC)) u_dut (.sys_clk(sys_clk), .rstn(rstn), .wb_req(wb_req),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pins(pins), .power_lamp(power_lamp),
		.error_lamp(error_lamp), .feed_motor(feed_motor), .print_enable(print_enable), .irq(irq));
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat);
		int n;
		n = 0;
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: adr, dat: dat};
		do begin
			@(posedge sys_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (n >= 20) begin
			n_mismatch++;
			complete_run();
		end else begin
			rd = wb_dat_o;
			wb_req <= '0;
			@(posedge sys_clk);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic power_cycle;
		rstn <= 1'b0;
		cyc(2);
		rstn <= 1'b1;
	endtask
	function automatic logic lamp(input int i);
		return i == 6 ? power_lamp : error_lamp;
	endfunction
	initial begin
		int n;
		int low;
		power_cycle();
		cyc(30);
		chk(power_lamp, 1, "green idle");
		wb(0, pfi_pkg::REG_STATUS, 0);
		chk(rd, 0, "status idle");
		wb(1, pfi_pkg::REG_MASK, 32'h00000200);
		cond <= 10'h200;
		cyc(10);
		chk({irq, print_enable}, 2'h3, "near end irq");
		wb(0, pfi_pkg::REG_COND, 0);
		chk(rd, 32'h00010200, "live conditions");
		cond <= 10'h240;
		wb(0, pfi_pkg::REG_STATUS, 0);
		chk(rd, 32'h00000200, "status events");
		cyc(10);
		chk(irq, 0, "masked event");
		wb(1, pfi_pkg::REG_MASK, 32'h00000240);
		chk(irq, 1, "unmasked event");
		wb(0, pfi_pkg::REG_STATUS, 0);
		chk(rd, 32'h00000040, "read clears");
		chk(irq, 0, "irq after read");
		wb(0, 4'h2, 0);
		chk(rd, 0, "unmapped");
		wb(1, pfi_pkg::REG_CTRL, 1);
		chk(feed_motor, 1, "soft feed");
		wb(1, pfi_pkg::REG_CTRL, 0);
		feed <= 1'b1;
		cyc(5);
		chk(feed_motor, 1, "button feed");
		feed <= 1'b0;
		cond <= 10'h080;
		cyc(10);
		chk({power_lamp, error_lamp, feed_motor, print_enable}, 4'hC, "cover");
		for (int i = 0; i < 10; i++) begin
			if (i == 7) continue;
			power_cycle();
			cond <= 10'h001 << i;
			cyc(40);
			chk(i == 6 ? error_lamp : power_lamp, i > 7, "steady lamp");
			n = 0;
			low = 0;
			while (lamp(i) !== 1'b0 && n < 20000) begin
				cyc(1);
				n++;
			end
			while (lamp(i) !== 1'b1 && n < 20000) begin
				cyc(1);
				n++;
				low++;
			end
			chk(n < 20000, 1, "flash seen");
			chk(low, ms[i] * TC, "flash half");
			cond <= 10'h000;
			cyc(10);
			chk({power_lamp, error_lamp && i > 5}, i > 5 ? 2'h2 : 2'h0, "after clear");
		end
		cond <= 10'h100;
		cyc(10);
		cond <= 10'h080;
		cyc(10);
		wb(0, pfi_pkg::REG_COND, 0);
		chk(rd, 32'h00030180, "roll seen under open cover");
		cond <= 10'h000;
		cyc(10);
		chk({power_lamp, error_lamp}, 2'h2, "paper cleared");
		stuck <= 1'b1;
		power_cycle();
		cond <= 10'h080;
		cyc(pfi_pkg::HOME_TIMEOUT_MS * TC + 20);
		stuck <= 1'b0;
		cyc(40);
		chk(power_lamp, 0, "cutter never homed");
		cond <= 10'h000;
		power_cycle();
		cyc(40);
		chk(power_lamp, 1, "power cycle clears");
		complete_run();
	end
endmodule
